// file: shared/adc_seq_pkg.sv
/*
 * Shared constants and types of the converter sequencer: control byte layout,
 * register reset values, state encoding and timing counts.
 * Assumes a single 100 MHz system clock; the internal oscillator is an enable.
 */
// What this block does
// - Byte MSB one is setup, zero configuration.
// - Setup bit 0 is ignored entirely.
// - Internal: track at ninth fall, hold two ticks later.
// - Internal: eight ticks per conversion, clock held low.
// - External: track seventh fall, hold eighth fall.
// - External: conversion uses next eight bus clocks.
// - Eight-step successive approximation, eight-bit result.
// - Single-ended converts selected channel against ground.
// - Pseudo-differential converts selected pair difference.
// - Unipolar: negative input gives code zero.
// - Bipolar covers half reference around negative input.
// - Straight binary unipolar, two's complement bipolar.
// - Single-ended always unipolar, polarity bit ignored.
// - Release stretched clock only after results stored.
package adc_seq_pkg;

    // ====================================================================
    // Control byte layout
    localparam int SEL_BIT = 7;
    localparam int REF_HI = 6;
    localparam int REF_LO = 4;
    localparam int CLK_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int CFGRST_BIT = 1;
    localparam int CNT_HI = 6;
    localparam int CNT_LO = 5;
    localparam int CS_HI = 4;
    localparam int CS_LO = 1;
    localparam int SGL_BIT = 0;

    // ====================================================================
    // Register types and values after reset
    typedef logic [7:0] code_t;
    typedef struct packed {
        logic [2:0] refChoice;
        logic extClock;
        logic polaritySelect;
    } setup_t;
    typedef struct packed {
        logic [1:0] extraConv;
        logic [3:0] channel;
        logic inputModeSelect;
    } config_t;
    localparam setup_t SETUP_RESET = '{refChoice: 3'h0, extClock: 1'b0, polaritySelect: 1'b0};
    localparam config_t CONFIG_RESET = '{extraConv: 2'h0, channel: 4'h0, inputModeSelect: 1'b1};

    // ====================================================================
    // Sequencer states
    typedef enum logic [2:0] {IDLE, EXT_TRACK, EXT_CONV, INT_TRACK, INT_CONV} seq_state_t;

    // ====================================================================
    // Timing and counts
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 800;
    localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [6:0] OSC_DIV_LAST = 7'(OSC_DIV - 1);
    localparam logic [3:0] TRACK_EDGE_EXT = 4'h7;
    localparam logic [3:0] HOLD_EDGE_EXT = 4'h8;
    localparam logic [3:0] TRACK_EDGE_INT = 4'h9;
    localparam logic [1:0] ACQ_LAST = 2'h1;
    localparam code_t SAR_FIRST = 8'h80;
    localparam logic [3:0] SAR_STEPS = 4'h8;
    localparam int RESULT_DEPTH = 8;

endpackage

// file: verilog/sar_search.sv
/*
 * Successive-approximation search register: one trial bit per step.
 * Assumes the comparator output is settled and synchronous when step is high.
 */
`timescale 1ns/1ps
`default_nettype none
module sar_search (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Search control.
    input wire logic start,
    input wire logic step,
    input wire logic cmpHigh,
    // Search outputs.
    output adc_seq_pkg::code_t trialCode,
    output adc_seq_pkg::code_t rawCode,
    output logic done
);
    import adc_seq_pkg::*;

    code_t trial_ff;
    code_t mask_ff;
    code_t code_ff;
    logic done_ff;

    // A kept bit stays when the input is above the trial level.
    wire code_t kept = cmpHigh ? trial_ff : (trial_ff & ~mask_ff);
    wire code_t nxt_mask = start ? SAR_FIRST : {1'b0, mask_ff[7:1]};
    wire code_t nxt_trial = start ? SAR_FIRST : (kept | {1'b0, mask_ff[7:1]});
    wire lastStep = step && mask_ff[0];

    // The mask empties after the eighth step, so stray steps change nothing.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trial_ff <= 8'h00;
            mask_ff <= 8'h00;
            code_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            if (start || step) begin
                trial_ff <= nxt_trial;
                mask_ff <= nxt_mask;
            end
            done_ff <= lastStep;
            if (lastStep) begin
                code_ff <= kept;
            end
        end
    end

    assign trialCode = trial_ff;
    assign rawCode = code_ff;
    assign done = done_ff;
endmodule
`default_nettype wire

// file: verilog/adc_track_hold_sequencer.sv
/*
 * Track, hold and conversion sequencer of an 8-bit converter, with setup and
 * configuration registers loaded from received control bytes.
 * Assumes a bus front end on clk that reports START, address match and data
 * bytes already acknowledged; the comparator outputs are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_track_hold_sequencer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Bus clock pin, open drain.
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    // Bus front end events.
    input wire logic startSeen,
    input wire logic addrMatch,
    input wire logic addrRead,
    input wire logic wrByteValid,
    input wire logic [7:0] wrByte,
    // Analog comparator.
    input wire logic cmpHigh,
    input wire logic diffNegative,
    // Analog control.
    output logic [2:0] refChoice,
    output logic [3:0] channel,
    output logic pseudoDiff,
    output logic tracking,
    output logic holding,
    output adc_seq_pkg::code_t dacCode,
    // Result memory.
    input wire logic [2:0] rdIndex,
    output adc_seq_pkg::code_t rdData,
    output logic [3:0] resultCount
);
    import adc_seq_pkg::*;

    // Hold rises one cycle after the second tick, which lands 81 to 160 cycles after the begin.
    localparam int HOLD_MIN = OSC_DIV + 2;
    localparam int HOLD_MAX = 2 * OSC_DIV + 1;

    logic scl1_ff, scl2_ff, scl3_ff, sclLvl_ff;
    logic [3:0] edgeCnt_ff;
    logic addrOk_ff, addrRd_ff;
    setup_t setup_ff, convSetup_ff;
    config_t config_ff, convCfg_ff;
    logic [6:0] oscCnt_ff;
    seq_state_t state_ff, nxt_state;
    logic [1:0] acqCnt_ff, nxt_acq;
    logic [1:0] left_ff, nxt_left;
    logic negLatch_ff, sclOe_ff;
    logic [2:0] wrIdx_ff;
    logic [3:0] count_ff;
    code_t mem_ff [RESULT_DEPTH];
    code_t rdData_ff;
    code_t rawCode;
    logic sarDone;

    // ====================================================================
    // Bus clock sampling
    // The pin level counts only when the second and third stages agree.
    wire sclAgree = (scl2_ff == scl3_ff);
    wire sclFall = sclAgree && sclLvl_ff && !scl3_ff;
    wire [3:0] fallNum = edgeCnt_ff + 4'h1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl1_ff <= 1'b1;
            scl2_ff <= 1'b1;
            scl3_ff <= 1'b1;
            sclLvl_ff <= 1'b1;
        end else begin
            scl1_ff <= sclIn;
            scl2_ff <= scl1_ff;
            scl3_ff <= scl2_ff;
            if (sclAgree) begin
                sclLvl_ff <= scl3_ff;
            end
        end
    end

    // Falling edges since START, saturating so a long frame cannot wrap to 7.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edgeCnt_ff <= 4'h0;
            addrOk_ff <= 1'b0;
            addrRd_ff <= 1'b0;
        end else if (startSeen) begin
            edgeCnt_ff <= 4'h0;
            addrOk_ff <= 1'b0;
            addrRd_ff <= 1'b0;
        end else begin
            if (sclFall && edgeCnt_ff != 4'hF) begin
                edgeCnt_ff <= fallNum;
            end
            if (addrMatch) begin
                addrOk_ff <= 1'b1;
                addrRd_ff <= addrRead;
            end
        end
    end

    // ====================================================================
    // Setup and configuration registers
    wire isSetup = wrByteValid && wrByte[SEL_BIT];
    wire isConfig = wrByteValid && !wrByte[SEL_BIT];
    wire cfgReset = isSetup && !wrByte[CFGRST_BIT];
    // Bit 0 of the setup byte is never looked at.
    wire setup_t setupIn = '{refChoice: wrByte[REF_HI:REF_LO], extClock: wrByte[CLK_BIT],
                             polaritySelect: wrByte[POL_BIT]};
    wire config_t configIn = '{extraConv: wrByte[CNT_HI:CNT_LO], channel: wrByte[CS_HI:CS_LO],
                               inputModeSelect: wrByte[SGL_BIT]};

    // All setup fields load in one edge, so no mix of old and new is seen.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            setup_ff <= SETUP_RESET;
            config_ff <= CONFIG_RESET;
        end else begin
            if (isSetup) begin
                setup_ff <= setupIn;
            end
            if (cfgReset) begin
                config_ff <= CONFIG_RESET;
            end else if (isConfig) begin
                config_ff <= configIn;
            end
        end
    end

    // ====================================================================
    // Internal oscillator as a one-cycle enable
    wire oscTick = (oscCnt_ff == OSC_DIV_LAST);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oscCnt_ff <= 7'h00;
        end else begin
            oscCnt_ff <= oscTick ? 7'h00 : oscCnt_ff + 7'h01;
        end
    end

    // ====================================================================
    // Sequencer
    wire extMode = setup_ff.extClock;
    wire extBegin = sclFall && extMode && (fallNum == TRACK_EDGE_EXT);
    // Conversions in internal mode are launched only by a read address.
    wire intBegin = sclFall && !extMode && (fallNum == TRACK_EDGE_INT) && addrOk_ff && addrRd_ff;
    wire seriesBegin = (state_ff == IDLE) && (extBegin || intBegin);
    wire acqDone = oscTick && (acqCnt_ff == ACQ_LAST);
    wire sarStart = ((state_ff == EXT_TRACK) && sclFall) || ((state_ff == INT_TRACK) && acqDone);
    wire sarStep = ((state_ff == EXT_CONV) && sclFall) || ((state_ff == INT_CONV) && oscTick);
    // Tracking starts before the address is complete; a miss drops the sample.
    wire extAbort = (state_ff == EXT_CONV) && sclFall && (fallNum == TRACK_EDGE_INT) && !addrOk_ff;
    wire storeEn = sarDone && (state_ff == EXT_CONV || state_ff == INT_CONV);

    always_comb begin
        nxt_state = state_ff;
        nxt_acq = acqCnt_ff;
        nxt_left = left_ff;
        case (state_ff)
            IDLE: begin
                if (extBegin) begin
                    nxt_state = EXT_TRACK;
                end else if (intBegin) begin
                    nxt_state = INT_TRACK;
                    nxt_acq = 2'h0;
                    nxt_left = config_ff.extraConv;
                end
            end
            EXT_TRACK: begin
                if (sclFall) begin
                    nxt_state = EXT_CONV;
                end
            end
            EXT_CONV: begin
                if (extAbort || sarDone) begin
                    nxt_state = IDLE;
                end
            end
            INT_TRACK: begin
                if (oscTick) begin
                    nxt_acq = acqCnt_ff + 2'h1;
                end
                if (acqDone) begin
                    nxt_state = INT_CONV;
                end
            end
            INT_CONV: begin
                if (sarDone && left_ff != 2'h0) begin
                    nxt_state = INT_TRACK;
                    nxt_acq = 2'h0;
                    nxt_left = left_ff - 2'h1;
                end else if (sarDone) begin
                    nxt_state = IDLE;
                end
            end
            default: begin
                nxt_state = IDLE;
            end
        endcase
    end

    // The stretch follows the next state, so it drops on the edge that stores the last result.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= IDLE;
            acqCnt_ff <= 2'h0;
            left_ff <= 2'h0;
            sclOe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            acqCnt_ff <= nxt_acq;
            left_ff <= nxt_left;
            sclOe_ff <= (nxt_state == INT_TRACK) || (nxt_state == INT_CONV);
        end
    end

    // Polarity, channel and input mode are frozen per series; refChoice follows a setup byte mid-conversion at once.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            convSetup_ff <= SETUP_RESET;
            convCfg_ff <= CONFIG_RESET;
            negLatch_ff <= 1'b0;
        end else begin
            if (seriesBegin) begin
                convSetup_ff <= setup_ff;
                convCfg_ff <= config_ff;
            end
            if (sarStart) begin
                negLatch_ff <= diffNegative;
            end
        end
    end

    sar_search u_sar (
        .clk(clk),
        .rst(rst),
        .start(sarStart),
        .step(sarStep),
        .cmpHigh(cmpHigh),
        .trialCode(dacCode),
        .rawCode(rawCode),
        .done(sarDone)
    );

    // ====================================================================
    // Result coding and memory
    wire bipEff = convSetup_ff.polaritySelect && !convCfg_ff.inputModeSelect;
    // Bipolar flips the MSB of the offset search into two's complement.
    wire code_t coded = bipEff ? {~rawCode[7], rawCode[6:0]} : (negLatch_ff ? 8'h00 : rawCode);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrIdx_ff <= 3'h0;
            count_ff <= 4'h0;
            rdData_ff <= 8'h00;
        end else begin
            if (seriesBegin) begin
                wrIdx_ff <= 3'h0;
                count_ff <= 4'h0;
            end else if (storeEn) begin
                wrIdx_ff <= wrIdx_ff + 3'h1;
                count_ff <= count_ff + 4'h1;
            end
            rdData_ff <= mem_ff[rdIndex];
        end
    end

    for (genvar i = 0; i < RESULT_DEPTH; i++) begin : g_mem
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                mem_ff[i] <= 8'h00;
            end else if (storeEn && wrIdx_ff == 3'(i)) begin
                mem_ff[i] <= coded;
            end
        end
    end

    // ====================================================================
    // Outputs
    assign sclOut = 1'b0;
    assign sclOe = sclOe_ff;
    assign refChoice = setup_ff.refChoice;
    assign channel = convCfg_ff.channel;
    assign pseudoDiff = !convCfg_ff.inputModeSelect;
    assign tracking = (state_ff == EXT_TRACK) || (state_ff == INT_TRACK);
    assign holding = (state_ff == EXT_CONV) || (state_ff == INT_CONV);
    assign rdData = rdData_ff;
    assign resultCount = count_ff;

    // ====================================================================
    // Checks
    logic [3:0] stepCnt_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stepCnt_ff <= 4'h0;
        end else if (sarStart) begin
            stepCnt_ff <= 4'h0;
        end else if (sarStep) begin
            stepCnt_ff <= stepCnt_ff + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ext_track_edge: assert property (seriesBegin && extMode |=> tracking && !sclOe)
        else $error("External track did not start on the seventh fall.");
    a_ext_hold_edge: assert property ((state_ff == EXT_TRACK) && sclFall |=> holding && !tracking)
        else $error("External hold did not start on the eighth fall.");
    a_int_track_edge: assert property (seriesBegin && !extMode |=> tracking && sclOe)
        else $error("Internal track or stretch missing after ninth fall.");
    a_int_hold_delay: assert property (seriesBegin && !extMode |-> ##[HOLD_MIN:HOLD_MAX] $rose(holding))
        else $error("Internal hold not two oscillator ticks after track.");
    a_sar_step_count: assert property (storeEn |-> stepCnt_ff == SAR_STEPS)
        else $error("Conversion did not take eight steps.");
    a_ext_no_stretch: assert property (sclOe |-> !convSetup_ff.extClock)
        else $error("Bus clock stretched in external clock mode.");
    a_release_stored: assert property ($fell(sclOe) |-> $past(storeEn))
        else $error("Bus clock released before a result was stored.");
    a_setup_load: assert property (isSetup |=> setup_ff == $past(setupIn))
        else $error("Setup byte fields not loaded together.");
    a_cfg_default: assert property (cfgReset |=> config_ff == CONFIG_RESET)
        else $error("Configuration not restored to defaults.");
    a_cfg_load: assert property (isConfig |=> config_ff == $past(configIn) && $stable(setup_ff))
        else $error("Configuration byte decoded wrongly.");
    a_uni_negative: assert property (storeEn && !bipEff && negLatch_ff |=> mem_ff[$past(wrIdx_ff)] == 8'h00)
        else $error("Negative unipolar input did not give code zero.");
    a_sgl_unipolar: assert property (storeEn && convCfg_ff.inputModeSelect && !negLatch_ff |-> coded == rawCode)
        else $error("Single-ended result not straight binary.");

    c_ext_conv: cover property (storeEn && (state_ff == EXT_CONV));
    c_int_series: cover property (storeEn && (state_ff == INT_CONV) && left_ff != 2'h0);
    c_cfg_reset: cover property (cfgReset);
    c_bipolar: cover property (storeEn && bipEff);
endmodule
`default_nettype wire

// file: dv/bus_master_model.sv
/*
 * Behavioural two-wire bus master: frames of bus-clock falls with front end events.
 * Assumes the device pulls the clock line low through sclOe; the line has a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    // Clock and line.
    input wire logic clk,
    input wire logic sclOe,
    output logic sclIn,
    // Front end events.
    output logic startSeen,
    output logic addrMatch,
    output logic addrRead,
    output int falls
);
    logic sclDrv;

    // ==========================================================
    // Open-drain line: the pull-up wins unless someone pulls low.
    assign sclIn = sclDrv & ~sclOe;

    initial begin
        sclDrv = 1'b1;
        startSeen = 1'b0;
        addrMatch = 1'b0;
        addrRead = 1'b0;
        falls = 0;
    end

    // One frame of n clock periods of 160 ns; the clock stands high between frames.
    task automatic frame(input logic match, input logic rd, input int n, output logic hung);
        int w;
        hung = 1'b0;
        startSeen <= 1'b1;
        addrRead <= rd;
        falls <= 0;
        @(posedge clk);
        startSeen <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 1; i <= n; i++) begin
            sclDrv <= 1'b0;
            falls <= i;
            repeat (8) @(posedge clk);
            sclDrv <= 1'b1;
            addrMatch <= (i == 8) ? match : 1'b0;
            @(posedge clk);
            addrMatch <= 1'b0;
            w = 0;
            // A stretched line is waited out, but never without a bound.
            while (sclIn !== 1'b1 && w < 5000) begin
                @(posedge clk);
                w++;
            end
            if (w >= 5000) hung = 1'b1;
            repeat (7) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// file: dv/adc_track_hold_sequencer_tb_top.sv
/*
 * Self-checking bench of the sequencer with a bus master model and comparator model.
 * Assumes the package constants and the hand-over timing of the designer.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH at %0t: got %0h want %0h", $time, a, e); end end
module adc_track_hold_sequencer_tb_top;
    import adc_seq_pkg::*;
    logic clk, rst, sclIn, sclOut, sclOe, startSeen, addrMatch, addrRead, wrByteValid;
    logic cmpHigh, diffNegative, pseudoDiff, tracking, holding, trkQ, hldQ, oeSeen, hung;
    logic [7:0] wrByte;
    logic [2:0] refChoice, rdIndex;
    logic [3:0] channel, resultCount;
    logic [1:0] x;
    code_t dacCode, rdData, vin, b;
    int errors, total_checks, falls, trkLen, hldLen, trkFall, hldFall;

    // ==========================================================
    // Clock, comparator model and timing monitor.
    always #5 clk = ~clk;
    assign cmpHigh = (vin >= dacCode);
    always @(posedge clk) begin
        trkQ <= tracking;
        hldQ <= holding;
        if (tracking && !trkQ) begin
            trkLen = 0;
            trkFall = falls;
        end
        if (tracking) trkLen++;
        if (holding && !hldQ) begin
            hldLen = 0;
            hldFall = falls;
        end
        if (holding) hldLen++;
        if (sclOe) oeSeen = 1'b1;
    end

    adc_track_hold_sequencer adc_track_hold_sequencer_i (.clk(clk), .rst(rst), .sclIn(sclIn),
        .sclOut(sclOut), .sclOe(sclOe), .startSeen(startSeen), .addrMatch(addrMatch),
        .addrRead(addrRead), .wrByteValid(wrByteValid), .wrByte(wrByte), .cmpHigh(cmpHigh),
        .diffNegative(diffNegative), .refChoice(refChoice), .channel(channel),
        .pseudoDiff(pseudoDiff), .tracking(tracking), .holding(holding), .dacCode(dacCode),
        .rdIndex(rdIndex), .rdData(rdData), .resultCount(resultCount));
    bus_master_model bus_master_model_i (.clk(clk), .sclOe(sclOe), .sclIn(sclIn),
        .startSeen(startSeen), .addrMatch(addrMatch), .addrRead(addrRead), .falls(falls));

    // ==========================================================
    // Reference model: only bipolar pseudo-differential flips the top bit.
    function automatic code_t exp_code(input logic pse, pol, neg, input code_t v);
        if (pse && pol) return v ^ 8'h80;
        if (neg) return 8'h00;
        return v;
    endfunction

    task automatic wr(input logic [7:0] d);
        wrByteValid <= 1'b1;
        wrByte <= d;
        @(posedge clk);
        wrByteValid <= 1'b0;
        @(posedge clk);
    endtask

    // One series: program, frame, then read back every stored result.
    task automatic run_conv(input logic e, pse, pol, rd, input int n, input logic [1:0] extra);
        logic neg;
        logic [3:0] ch;
        neg = pse & 1'($urandom());
        ch = 4'($urandom());
        vin <= 8'($urandom());
        diffNegative <= neg;
        wr({1'b1, 3'($urandom()), e, pol, 1'b1, 1'($urandom())});
        wr({1'b0, extra, ch, ~pse});
        oeSeen = 1'b0;
        bus_master_model_i.frame(1'b1, rd, n, hung);
        `CHK(hung, 1'b0)
        `CHK(resultCount, 4'(extra + 1))
        `CHK(channel, ch)
        `CHK(pseudoDiff, pse)
        for (int i = 0; i <= extra; i++) begin
            rdIndex <= 3'(i);
            repeat (2) @(posedge clk);
            `CHK(rdData, exp_code(pse, pol, neg, vin))
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        wrByteValid = 1'b0;
        wrByte = 8'h00;
        diffNegative = 1'b0;
        rdIndex = 3'h0;
        vin = 8'h00;
        errors = 0;
        total_checks = 0;
        void'($urandom(32'h3c36_1131));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(refChoice, 3'h0)
        `CHK(pseudoDiff, 1'b0)
        `CHK(sclOe, 1'b0)
        `CHK(sclOut, 1'b0)
        `CHK(resultCount, 4'h0)
        // Byte decode; a setup byte with the reset bit high keeps the configuration.
        // The channel pins follow the snapshot of a series, so the register itself is watched here.
        for (int i = 0; i < 8; i++) begin
            b = 8'($urandom());
            wr(b & 8'h7f);
            wr(b | 8'h82);
            `CHK(refChoice, b[6:4])
            `CHK(adc_track_hold_sequencer_i.config_ff.channel, b[4:1])
            `CHK(adc_track_hold_sequencer_i.config_ff.inputModeSelect, b[0])
            wr({1'b1, ~b[6:4], b[3:2], 1'b0, b[0]});
            `CHK(refChoice, ~b[6:4])
            `CHK(adc_track_hold_sequencer_i.config_ff, CONFIG_RESET)
        end
        // Internal clock mode, every input and polarity combination.
        for (int m = 0; m < 4; m++) begin
            x = 2'($urandom());
            run_conv(1'b0, m[1], m[0], 1'b1, 9, x);
            `CHK(oeSeen, 1'b1)
            `CHK(trkFall, 9)
            `CHK(trkLen inside {[78:162]}, 1'b1)
            `CHK(hldLen inside {[639:642]}, 1'b1)
        end
        // A write-direction address starts nothing; the count still shows the last series.
        oeSeen = 1'b0;
        bus_master_model_i.frame(1'b1, 1'b0, 9, hung);
        `CHK(hung, 1'b0)
        `CHK(oeSeen, 1'b0)
        `CHK(resultCount, 4'(x) + 4'h1)
        // External clock mode follows the master's clock and never stretches.
        for (int m = 0; m < 4; m++) begin
            run_conv(1'b1, m[1], m[0], 1'($urandom()), 18, 2'h0);
            `CHK(oeSeen, 1'b0)
            `CHK(trkFall, 7)
            `CHK(hldFall, 8)
            `CHK(hldLen inside {[124:132]}, 1'b1)
        end
        // A frame whose address is not ours drops the tracked sample and stores nothing.
        bus_master_model_i.frame(1'b0, 1'b0, 18, hung);
        `CHK(hung, 1'b0)
        `CHK(resultCount, 4'h0)
        conclude();
    end
endmodule
`default_nettype wire
